// ==== verilog/avcr_top.sv ====
// Local design decision: the APB register port.
`timescale 1ns/100ps
module avcr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [6:0] headphone_driver_code,
  output logic [9:0] headphone_driver_atten,
  output logic headphone_driver_mute,
  output logic [6:0] left_analog_input_code,
  output logic [9:0] left_analog_input_atten,
  output logic left_analog_input_mute,
  output logic mixer_force_on
);
  import avcr_pkg::*;

  typedef struct packed {
    logic [6:0] hp_vol;
    logic [6:0] left_analog_input_vol;
    logic mix_force;
    logic [31:0] rdata;
  } avcr_st_t;

  avcr_st_t st_ff;
  avcr_st_t nxt_st;
  logic setup_ph;
  logic access_ph;
  logic addr_hit;

  avcr_dec_if hp_if ();
  avcr_dec_if left_analog_input_if ();

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  // Read data is captured in the setup cycle, so the access phase can finish at once.
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_hit = (paddr == ADDR_HP_VOL) || (paddr == ADDR_RSVD) || (paddr == ADDR_LEFT_ANALOG_INPUT_VOL);
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_hit; // Unmapped words error and write nothing.

  // ****************************************************************
  // Register update and read capture.
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    if (setup_ph && !pwrite) begin
      case (paddr)
        ADDR_HP_VOL: begin
          nxt_st.rdata = {25'h0000000, st_ff.hp_vol}; // D7 reads zero.
        end
        ADDR_RSVD: begin
          nxt_st.rdata = {24'h000000, RSVD_VAL};
        end
        ADDR_LEFT_ANALOG_INPUT_VOL: begin
          nxt_st.rdata = {24'h000000, st_ff.mix_force, st_ff.left_analog_input_vol};
        end
        default: begin
          nxt_st.rdata = 32'h00000000;
        end
      endcase
    end
    if (access_ph && pwrite) begin
      case (paddr)
        ADDR_HP_VOL: begin
          nxt_st.hp_vol = pwdata[VOL_MSB:0];
        end
        ADDR_LEFT_ANALOG_INPUT_VOL: begin
          nxt_st.left_analog_input_vol = pwdata[VOL_MSB:0];
          nxt_st.mix_force = pwdata[MIX_FORCE_BIT];
        end
        default: begin
          // The reserved slot holds no storage, so a stray write cannot disturb it.
          nxt_st.hp_vol = st_ff.hp_vol;
        end
      endcase
    end
  end

  // All fields clear on reset, which is code zero, 0.0dB and mixers not forced.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{hp_vol: HP_VOL_RST[VOL_MSB:0], left_analog_input_vol: LEFT_ANALOG_INPUT_VOL_RST[VOL_MSB:0],
                 mix_force: LEFT_ANALOG_INPUT_VOL_RST[MIX_FORCE_BIT], rdata: 32'h00000000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Gain decoders, fed straight from the stored codes.
  // ****************************************************************
  assign hp_if.code = st_ff.hp_vol;
  assign left_analog_input_if.code = st_ff.left_analog_input_vol;

  avcr_decode u_hp_dec (
    .pclk(pclk),
    .presetn(presetn),
    .dec(hp_if)
  );

  avcr_decode u_left_analog_input_dec (
    .pclk(pclk),
    .presetn(presetn),
    .dec(left_analog_input_if)
  );

  assign prdata = st_ff.rdata;
  assign headphone_driver_code = st_ff.hp_vol;
  assign headphone_driver_atten = hp_if.atten;
  assign headphone_driver_mute = hp_if.mute;
  assign left_analog_input_code = st_ff.left_analog_input_vol;
  assign left_analog_input_atten = left_analog_input_if.atten;
  assign left_analog_input_mute = left_analog_input_if.mute;
  assign mixer_force_on = st_ff.mix_force;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  rsvd_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && paddr == 8'h5C |=> prdata == 32'h00000000)
    else $error("reserved slot read not zero");
  rsvd_no_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && paddr == 8'h5C |=> $stable(headphone_driver_code) && $stable(left_analog_input_code)
      && $stable(mixer_force_on))
    else $error("reserved write changed state");
  mix_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && paddr == 8'h60 |=> mixer_force_on == $past(pwdata[7]))
    else $error("mixer force not taken from bit 7");
  left_analog_input_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && paddr == 8'h60 |=> left_analog_input_code == $past(pwdata[6:0]))
    else $error("left input code not stored");
  left_analog_input_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && paddr == 8'h60 |=> prdata == {24'h000000, mixer_force_on, left_analog_input_code})
    else $error("left input readback wrong");
  hp_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && paddr == 8'h58 |=> prdata[31:7] == 25'h0000000 && prdata[6:0] == headphone_driver_code)
    else $error("headphone readback wrong");
  hp_takes_effect_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && paddr == 8'h58 |=> ##1 {headphone_driver_mute, headphone_driver_atten}
      == avcr_atten_f($past(pwdata[6:0], 2)))
    else $error("headphone gain not updated two edges after write");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    access_ph && paddr != 8'h58 && paddr != 8'h5C && paddr != 8'h60 |-> pslverr && pready)
    else $error("unmapped access not errored");

endmodule : avcr_top

// ==== common/avcr_pkg.sv ====
package avcr_pkg;

  // ****************************************************************
  // Register map: printed offsets are word indices, byte address is four times that.
  // ****************************************************************
  localparam logic [5:0] IDX_HP_VOL = 6'h16;
  localparam logic [5:0] IDX_RSVD = 6'h17;
  localparam logic [5:0] IDX_LEFT_ANALOG_INPUT_VOL = 6'h18;
  localparam logic [7:0] ADDR_HP_VOL = {IDX_HP_VOL, 2'b00};
  localparam logic [7:0] ADDR_RSVD = {IDX_RSVD, 2'b00};
  localparam logic [7:0] ADDR_LEFT_ANALOG_INPUT_VOL = {IDX_LEFT_ANALOG_INPUT_VOL, 2'b00};

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int MIX_FORCE_BIT = 7;
  localparam int VOL_MSB = 6;
  localparam logic [7:0] HP_VOL_RST = 8'h00;
  localparam logic [7:0] LEFT_ANALOG_INPUT_VOL_RST = 8'h00;
  localparam logic [7:0] RSVD_VAL = 8'h00;

  // ****************************************************************
  // Attenuation codes, in tenths of a decibel.
  // ****************************************************************
  localparam logic [6:0] LAST_FINITE_CODE = 7'h74;
  localparam logic [6:0] MUTE_CODE = 7'h75;
  localparam logic [9:0] ATTEN_MUTE = 10'h3FF;
  localparam logic [0:116][9:0] ATTEN_TBL = {
    10'h000, 10'h005, 10'h00A, 10'h00F, 10'h014, 10'h019, 10'h01E, 10'h023, 10'h028, 10'h02D,
    10'h032, 10'h037, 10'h03C, 10'h041, 10'h046, 10'h04B, 10'h050, 10'h055, 10'h05A, 10'h05A,
    10'h064, 10'h069, 10'h06E, 10'h073, 10'h078, 10'h07D, 10'h082, 10'h087, 10'h08D, 10'h092,
    10'h097, 10'h09C, 10'h0A0, 10'h0A5, 10'h0AB, 10'h0AF, 10'h0B5, 10'h0BA, 10'h0BF, 10'h0C4,
    10'h0C9, 10'h0CE, 10'h0D3, 10'h0D8, 10'h0DD, 10'h0E2, 10'h0E7, 10'h0EC, 10'h0F1, 10'h0F6,
    10'h0FB, 10'h100, 10'h105, 10'h10A, 10'h10F, 10'h114, 10'h119, 10'h11E, 10'h123, 10'h128,
    10'h12D, 10'h132, 10'h137, 10'h13C, 10'h141, 10'h146, 10'h14B, 10'h150, 10'h155, 10'h155,
    10'h160, 10'h165, 10'h169, 10'h16F, 10'h174, 10'h179, 10'h17E, 10'h183, 10'h188, 10'h18D,
    10'h192, 10'h197, 10'h19C, 10'h1A2, 10'h1A5, 10'h1AB, 10'h1B0, 10'h1B6, 10'h1BB, 10'h1C0,
    10'h1C4, 10'h1CA, 10'h1CE, 10'h1D3, 10'h1DA, 10'h1DF, 10'h1E2, 10'h1E7, 10'h1ED, 10'h1F4,
    10'h1F7, 10'h1FE, 10'h202, 10'h206, 10'h20B, 10'h20F, 10'h219, 10'h21E, 10'h22A, 10'h237,
    10'h247, 10'h259, 10'h273, 10'h283, 10'h296, 10'h29B, 10'h2D3};

  // Returns {mute, attenuation}; reserved codes mute, the safest thing to do with a bad code.
  function automatic logic [10:0] avcr_atten_f(input logic [6:0] code);
    logic [10:0] res;
    if (code > LAST_FINITE_CODE) begin
      res = {1'b1, ATTEN_MUTE};
    end else begin
      res = {1'b0, ATTEN_TBL[code]};
    end
    return res;
  endfunction : avcr_atten_f

endpackage : avcr_pkg

// ==== common/avcr_dec_if.sv ====
`timescale 1ns/100ps
// Carries one stored volume code to its decoder and the decoded gain back.
interface avcr_dec_if;
  logic [6:0] code;
  logic [9:0] atten;
  logic mute;
  modport regs (output code, input atten, input mute);
  modport dec (input code, output atten, output mute);
endinterface : avcr_dec_if

// ==== verilog/avcr_decode.sv ====
`timescale 1ns/100ps
module avcr_decode (
  input wire logic pclk,
  input wire logic presetn,
  avcr_dec_if.dec dec
);
  import avcr_pkg::*;

  typedef struct packed {
    logic [9:0] atten;
    logic mute;
  } avcr_dec_st_t;

  avcr_dec_st_t st_ff;
  avcr_dec_st_t nxt_st;

  // ****************************************************************
  // Lookup, registered so the gain stage sees a clean, glitch-free word.
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    {nxt_st.mute, nxt_st.atten} = avcr_atten_f(dec.code);
  end

  // Reset state matches code zero, so the stage starts at 0.0dB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{atten: 10'h000, mute: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dec.atten = st_ff.atten;
  assign dec.mute = st_ff.mute;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  mute_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    dec.code == 7'h75 |=> dec.mute && dec.atten == 10'h3FF)
    else $error("mute code did not mute");
  upper_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    dec.code == 7'h28 |=> !dec.mute && dec.atten == 10'h0C9)
    else $error("code 0x28 not -20.1dB");
  deep_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dec.code == 7'h6F |=> dec.atten == 10'h259) and (dec.code == 7'h74 |=> !dec.mute && dec.atten == 10'h2D3))
    else $error("deep attenuation codes wrong");
  first_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    dec.code == 7'h01 |=> !dec.mute && dec.atten == 10'h005)
    else $error("code 1 not -0.5dB");
  low_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    dec.code == 7'h27 |=> dec.atten == 10'h0C4 && !dec.mute)
    else $error("code 0x27 not -19.6dB");

endmodule : avcr_decode

// ==== dv/avcr_host.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Host controller model: an APB master with one transfer task.
// ****************************************************************
module avcr_host
  import avcr_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus idles from time zero so nothing is requested during reset.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One setup cycle, then access until pready; the request holds until that edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    logic [31:0] dd;
    dd = d;
    if (w && a == ADDR_RSVD) dd = 32'h0;
    if (w && a == ADDR_HP_VOL && dd[6:0] > MUTE_CODE) dd[6:0] = MUTE_CODE;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : avcr_host

// ==== dv/avcr_top_test.sv ====
`timescale 1ns/100ps
module avcr_top_test;
  import avcr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] hp_c, ai_c;
  logic [9:0] hp_a, ai_a;
  logic hp_mu, ai_mu, mix, e;
  logic [7:0] hp_m = 8'h00, ai_m = 8'h00;
  int error_cnt = 0, comparisons = 0, cycles = 0, seed = 32'h8B59;

  // ****************************************************************
  // Clock, design and host.
  // ****************************************************************
  always #2 pclk = ~pclk;
  avcr_top u_avcr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .headphone_driver_code(hp_c), .headphone_driver_atten(hp_a), .headphone_driver_mute(hp_mu),
    .left_analog_input_code(ai_c), .left_analog_input_atten(ai_a), .left_analog_input_mute(ai_mu),
    .mixer_force_on(mix));
  avcr_host u_avcr_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // Writes a register, then compares readback and every decoded output with the model.
  task automatic step(input logic [7:0] a, input logic [7:0] d, input logic [9:0] ha, input logic [9:0] aa);
    u_avcr_host.xfer(1'b1, a, {24'h0, d}, r, e);
    if (a == ADDR_HP_VOL) hp_m = {1'b0, d[6:0]};
    if (a == ADDR_LEFT_ANALOG_INPUT_VOL) ai_m = d;
    repeat (2) @(posedge pclk);
    u_avcr_host.xfer(1'b0, a, 32'h0, r, e);
    chk("readback", (a == ADDR_HP_VOL) ? {24'h0, hp_m} : (a == ADDR_LEFT_ANALOG_INPUT_VOL) ? {24'h0, ai_m} : 32'h0, r);
    chk("hp code", hp_m[6:0], hp_c);
    chk("hp atten", ha, hp_a);
    chk("hp mute", ha == 10'h3FF, hp_mu);
    chk("in code", ai_m[6:0], ai_c);
    chk("in atten", aa, ai_a);
    chk("in mute", 1'b0, ai_mu);
    chk("mixer force", ai_m[7], mix);
  endtask : step

  // A hang ends the run as a failure.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] hp_code [4] = '{8'h28, 8'hEF, 8'h74, 8'h75};
    logic [9:0] hp_exp [4] = '{10'd201, 10'd601, 10'd723, 10'h3FF};
    logic [7:0] c;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    step(ADDR_RSVD, 8'h00, 10'd0, 10'd0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) step(ADDR_HP_VOL, hp_code[i], hp_exp[i], 10'd0);
    $display("test headphone done");
    step(ADDR_LEFT_ANALOG_INPUT_VOL, 8'h81, 10'h3FF, 10'd5);
    step(ADDR_LEFT_ANALOG_INPUT_VOL, 8'h27, 10'h3FF, 10'd196);
    step(ADDR_LEFT_ANALOG_INPUT_VOL, 8'h00, 10'h3FF, 10'd0);
    for (int i = 0; i < 20; i++) begin
      c = 8'($random(seed));
      c[6:0] = c[6:0] % 19;
      step(ADDR_LEFT_ANALOG_INPUT_VOL, c, 10'h3FF, 10'(c[6:0] * 5));
    end
    $display("test left input done");
    u_avcr_host.xfer(1'b1, 8'h40, 32'h7F, r, e);
    chk("unmapped error", 1'b1, e);
    step(ADDR_RSVD, 8'h00, 10'h3FF, 10'(ai_m[6:0] * 5));
    $display("test unmapped done");
    wrap_up();
  end
endmodule : avcr_top_test
